/* dv/test_pcr_config_bank.sv */
/*
  test_pcr_config_bank: self-checking bench for the pump and lock
  configuration bank; register access, pump decode, mux pin and settle wait.
  Assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/10ps
module test_pcr_config_bank
  import pcr_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [PCR_AW-1:0] reg_addr = 8'h00;
  logic [PCR_DW-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [PCR_DW-1:0] reg_rdata;
  logic readback_sdo_in = 1'b0;
  logic lock_raw_in = 1'b0;
  logic settle_start = 1'b0;
  logic multiplexed_output_pin;
  logic lock_indicator_enable;
  logic lock_detect_out;
  pcr_pump_type int_pump;
  pcr_pump_type ext_pump;
  logic [PCR_WAIT_W-1:0] multiplier_settle_count;
  logic settle_busy;
  logic buffer_mute_until_locked;
  logic transmit_buffer_type;
  logic receive_buffer_type;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] offs [4] = '{8'h23, 8'h27, 8'h28, 8'h29};
  logic [15:0] pats [3] = '{16'hffff, 16'ha5c3, 16'h0000};
  logic [4:0] ups [4] = '{5'h00, 5'h01, 5'h1f, 5'h10};
  logic [10:0] waits [3] = '{11'h003, 11'h001, 11'h000};

  pcr_config_bank pcr_config_bank_inst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .readback_sdo_in(readback_sdo_in),
    .lock_raw_in(lock_raw_in),
    .settle_start(settle_start),
    .multiplexed_output_pin(multiplexed_output_pin),
    .lock_indicator_enable(lock_indicator_enable),
    .lock_detect_out(lock_detect_out),
    .int_pump(int_pump),
    .ext_pump(ext_pump),
    .multiplier_settle_count(multiplier_settle_count),
    .settle_busy(settle_busy),
    .buffer_mute_until_locked(buffer_mute_until_locked),
    .transmit_buffer_type(transmit_buffer_type),
    .receive_buffer_type(receive_buffer_type)
  );

  always #5 ref_clk = ~ref_clk;

  task automatic final_report();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // optional write, then read in the very next cycle, then idle data check
  task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {16'h0, exp}, {16'h0, reg_rdata});
    @(posedge ref_clk);
    #1;
    chk("reg_rdata_idle", 32'h0, {16'h0, reg_rdata});
  endtask

  function automatic pcr_pump_type pump_exp(input logic [5:0] base, input logic [1:0] g);
    pcr_pump_type e;
    logic [3:0] q;
    case (g)
      2'b00: q = 4'h4;
      2'b01: q = 4'h8;
      2'b10: q = 4'h6;
      default: q = 4'ha;
    endcase
    e.tristate = (base == 6'h00);
    e.base_code = base;
    e.gain_q = q;
    e.filter_code = 10'(base) * 10'(q);
    return e;
  endfunction

  task automatic check_resets();
    acc(1'b0, 8'h23, 16'h0000, 16'h0647);
    acc(1'b0, 8'h27, 16'h0000, 16'h11f0);
    acc(1'b0, 8'h28, 16'h0000, 16'h101c);
    acc(1'b0, 8'h29, 16'h0000, 16'h0810);
    chk("ext_pump", {11'h0, pump_exp(6'h20, 2'b00)}, {11'h0, ext_pump});
    chk("int_pump", {11'h0, pump_exp(6'h20, 2'b00)}, {11'h0, int_pump});
    chk("settle_count", 32'h0c8, {21'h0, multiplier_settle_count});
    chk("lock_enable", 32'h0, {31'h0, lock_indicator_enable});
    chk("buf_bits", 32'h7, {29'h0, buffer_mute_until_locked, transmit_buffer_type,
        receive_buffer_type});
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end

  initial begin
    int cnt;
    logic [3:0] m;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    check_resets();
    // full-width readback, all bits writable
    for (int i = 0; i < 4; i++) begin
      for (int p = 0; p < 3; p++) begin
        acc(1'b1, offs[i], pats[p], pats[p]);
      end
    end
    // unmapped places refused, no aliasing onto mapped ones
    acc(1'b1, 8'h2a, 16'h1234, 16'h0000);
    acc(1'b1, 8'h24, 16'h5678, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, offs[i], 16'h0000, 16'h0000);
    end
    // pump decode for every gain code and boundary current codes
    for (int i = 0; i < 4; i++) begin
      for (int g = 0; g < 4; g++) begin
        acc(1'b1, 8'h29, {4'h0, ups[i], 2'(g), ups[i]}, {4'h0, ups[i], 2'(g), ups[i]});
        acc(1'b1, 8'h28, {3'h0, ups[i], 2'(g), 6'h1c}, {3'h0, ups[i], 2'(g), 6'h1c});
        chk("ext_pump", {11'h0, pump_exp({ups[i], 1'b0}, 2'(g))},
            {11'h0, ext_pump});
        chk("int_pump", {11'h0, pump_exp({1'b0, ups[i]} + {1'b0, ups[i]}, 2'(g))},
            {11'h0, int_pump});
      end
    end
    // mux pin source and lock enable, all combinations
    for (int i = 0; i < 16; i++) begin
      m = 4'(i);
      acc(1'b1, 8'h27, {12'h11f, m[3], 2'b01, m[2]}, {12'h11f, m[3], 2'b01, m[2]});
      @(posedge ref_clk);
      readback_sdo_in <= m[1];
      lock_raw_in <= m[0];
      repeat (3) @(posedge ref_clk);
      #1;
      chk("lock_enable", {31'h0, m[2]}, {31'h0, lock_indicator_enable});
      chk("lock_detect", {31'h0, m[0] & m[2]}, {31'h0, lock_detect_out});
      chk("mux_pin", {31'h0, m[3] ? (m[0] & m[2]) : m[1]},
          {31'h0, multiplexed_output_pin});
    end
    // multiplier settle wait in reference cycles
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 8'h23, {2'b00, waits[i], 3'b010}, {2'b00, waits[i], 3'b010});
      chk("settle_count", {21'h0, waits[i]}, {21'h0, multiplier_settle_count});
      chk("buf_bits", 32'h2, {29'h0, buffer_mute_until_locked, transmit_buffer_type,
          receive_buffer_type});
      @(posedge ref_clk);
      settle_start <= 1'b1;
      @(posedge ref_clk);
      settle_start <= 1'b0;
      cnt = 0;
      repeat (12) begin
        #1;
        if (settle_busy === 1'b1) cnt++;
        @(posedge ref_clk);
      end
      chk("settle_busy_cycles", {21'h0, waits[i]}, 32'(cnt));
    end
    // second reset in mid-run restores every register
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    check_resets();
    final_report();
  end
endmodule

/* logic/pcr_config_bank.sv */
/*
  pcr_config_bank: pump current, lock detect and buffer configuration
  registers with decoded outputs and the multiplier settling timer.
  Assumes a plain register port on ref_clk; read data follow one cycle
  after the read strobe, and strobes never come together.
*/
`timescale 1ns/10ps

// Contract
// - External-loop up current sits in bits 11..7, resets to 10h, 0 is off, each code adds 312.5 uA.
// - External gain in bits 6..5 decodes 0=1x, 1=2x, 2=1.5x, 3=2.5x and resets to 0.
// - Internal down current sits in bits 4..0, resets to 10h, 0 is off, each code adds 156.25 uA.
// - Internal up current sits in bits 12..8, resets to 10h, and base is up plus down.
// - Internal gain in bits 7..6 resets to 0 and uses the same four-value gain table.
// - Loop filter current is the selected gain times the summed base current.
// - Lock register bit 3 routes readback data (0) or lock indication (1) to the mux pin.
// - Lock register bit 0 enables lock detect and resets to disabled.
// - External pump register lives at 29h, resets to 810h, all bits read/write.
// - Lock register lives at 27h resetting to 11F0h; internal pump at 28h resets to 101Ch.
// - Buffer register bits 13..3 give the multiplier settling wait in ref clock cycles.
module pcr_config_bank
  import pcr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [PCR_AW-1:0] reg_addr,
  input wire logic [PCR_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PCR_DW-1:0] reg_rdata,
  input wire logic readback_sdo_in,
  input wire logic lock_raw_in,
  input wire logic settle_start,
  output logic multiplexed_output_pin,
  output logic lock_indicator_enable,
  output logic lock_detect_out,
  output pcr_pump_type int_pump,
  output pcr_pump_type ext_pump,
  output logic [PCR_WAIT_W-1:0] multiplier_settle_count,
  output logic settle_busy,
  output logic buffer_mute_until_locked,
  output logic transmit_buffer_type,
  output logic receive_buffer_type
);

  logic [PCR_DW-1:0] buf_reg;
  logic [PCR_DW-1:0] buf_next;
  logic [PCR_DW-1:0] lock_reg;
  logic [PCR_DW-1:0] lock_next;
  logic [PCR_DW-1:0] int_reg;
  logic [PCR_DW-1:0] int_next;
  logic [PCR_DW-1:0] ext_reg;
  logic [PCR_DW-1:0] ext_next;
  logic [PCR_DW-1:0] rdata_reg;
  logic [PCR_DW-1:0] rdata_next;
  logic mux_reg;
  logic mux_next;
  logic lockdet_reg;
  logic lockdet_next;
  logic [4:0] ext_up_code;
  logic first_reg;

  // register writes
  always_comb begin
    buf_next = buf_reg;
    lock_next = lock_reg;
    int_next = int_reg;
    ext_next = ext_reg;
    if (reg_wr) begin
      case (reg_addr)
        PCR_OFF_BUF: buf_next = reg_wdata;
        PCR_OFF_LOCK: lock_next = reg_wdata;
        PCR_OFF_INT: int_next = reg_wdata;
        PCR_OFF_EXT: ext_next = reg_wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      buf_reg <= PCR_RST_BUF;
      lock_reg <= PCR_RST_LOCK;
      int_reg <= PCR_RST_INT;
      ext_reg <= PCR_RST_EXT;
    end else begin
      buf_reg <= buf_next;
      lock_reg <= lock_next;
      int_reg <= int_next;
      ext_reg <= ext_next;
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        PCR_OFF_BUF: rdata_next = buf_reg;
        PCR_OFF_LOCK: rdata_next = lock_reg;
        PCR_OFF_INT: rdata_next = int_reg;
        PCR_OFF_EXT: rdata_next = ext_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  // lock detect and mux pin
  always_comb begin
    lockdet_next = lock_reg[PCR_LOCK_EN_BIT] & lock_raw_in;
    if (lock_reg[PCR_LOCK_SEL_BIT]) begin
      mux_next = lockdet_reg;
    end else begin
      mux_next = readback_sdo_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
      mux_reg <= 1'b0;
      lockdet_reg <= 1'b0;
      first_reg <= 1'b1;
    end else begin
      rdata_reg <= rdata_next;
      mux_reg <= mux_next;
      lockdet_reg <= lockdet_next;
      first_reg <= 1'b0;
    end
  end

  assign reg_rdata = rdata_reg;
  assign multiplexed_output_pin = mux_reg;
  assign lock_detect_out = lockdet_reg;
  assign lock_indicator_enable = lock_reg[PCR_LOCK_EN_BIT];
  assign multiplier_settle_count = buf_reg[PCR_WAIT_HI:PCR_WAIT_LO];
  assign buffer_mute_until_locked = buf_reg[PCR_MUTE_BIT];
  assign transmit_buffer_type = buf_reg[PCR_TX_BIT];
  assign receive_buffer_type = buf_reg[PCR_RX_BIT];

  // external down code lives outside this bank and is kept equal to up
  assign ext_up_code = ext_reg[PCR_EXT_UP_HI:PCR_EXT_UP_LO];

  // pump decode: base sum, tri-state, gain and filter current
  pcr_pump_calc u_int_pump (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .up_code(int_reg[PCR_INT_UP_HI:PCR_INT_UP_LO]),
    .down_code(ext_reg[PCR_INT_DN_HI:PCR_INT_DN_LO]), // internal down code in ext register
    .gain_code(int_reg[PCR_INT_GAIN_HI:PCR_INT_GAIN_LO]),
    .pump(int_pump)
  );

  pcr_pump_calc u_ext_pump (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .up_code(ext_up_code),
    .down_code(ext_up_code),
    .gain_code(ext_reg[PCR_EXT_GAIN_HI:PCR_EXT_GAIN_LO]),
    .pump(ext_pump)
  );

  // multiplier settling wait in ref clock cycles
  pcr_settle_timer #(
    .W(PCR_WAIT_W)
  ) u_settle (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(settle_start),
    .count(multiplier_settle_count),
    .busy(settle_busy)
  );

  // checks
  property p_reset_values;
    @(posedge ref_clk) disable iff (!rstn)
      first_reg |-> (ext_reg == PCR_RST_EXT) && (lock_reg == PCR_RST_LOCK)
        && (int_reg == PCR_RST_INT) && (buf_reg == PCR_RST_BUF);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("register not at reset value after reset release");

  sequence s_write_int;
    reg_wr && (reg_addr == PCR_OFF_INT);
  endsequence

  sequence s_read_int;
    reg_rd && (reg_addr == PCR_OFF_INT);
  endsequence

  property p_write_readback;
    @(posedge ref_clk) disable iff (!rstn)
      s_write_int ##1 s_read_int |=> (reg_rdata == $past(reg_wdata, 2));
  endproperty
  a_write_readback: assert property (p_write_readback)
    else $error("readback differs from last written value");

  property p_ext_read;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_rd && (reg_addr == PCR_OFF_EXT)) |=> (reg_rdata == $past(ext_reg));
  endproperty
  a_ext_read: assert property (p_ext_read)
    else $error("external pump register readback wrong");

  property p_ext_base;
    @(posedge ref_clk) disable iff (!rstn)
      !first_reg |-> (ext_pump.base_code == {$past(ext_up_code), 1'b0})
        && (ext_pump.tristate == ($past(ext_up_code) == 5'h00));
  endproperty
  a_ext_base: assert property (p_ext_base)
    else $error("external base current not twice the up code");

  property p_ext_gain;
    @(posedge ref_clk) disable iff (!rstn)
      (ext_reg[PCR_EXT_GAIN_HI:PCR_EXT_GAIN_LO] == 2'h2) |=> (ext_pump.gain_q == 4'h6);
  endproperty
  a_ext_gain: assert property (p_ext_gain)
    else $error("external gain code 2 not decoded as 1.5x");

  property p_int_base;
    @(posedge ref_clk) disable iff (!rstn)
      !first_reg |-> int_pump.base_code
        == ({1'b0, $past(int_reg[12:8])} + {1'b0, $past(ext_reg[4:0])});
  endproperty
  a_int_base: assert property (p_int_base)
    else $error("internal base current not up plus down");

  property p_int_gain;
    @(posedge ref_clk) disable iff (!rstn)
      (int_reg[PCR_INT_GAIN_HI:PCR_INT_GAIN_LO] == 2'h3) |=> (int_pump.gain_q == 4'ha);
  endproperty
  a_int_gain: assert property (p_int_gain)
    else $error("internal gain code 3 not decoded as 2.5x");

  property p_filter_current;
    @(posedge ref_clk) disable iff (!rstn)
      (int_pump.filter_code == 10'(int_pump.base_code) * 10'(int_pump.gain_q))
        && (ext_pump.filter_code == 10'(ext_pump.base_code) * 10'(ext_pump.gain_q));
  endproperty
  a_filter_current: assert property (p_filter_current)
    else $error("filter current not gain times base");

  property p_mux_readback;
    @(posedge ref_clk) disable iff (!rstn)
      !lock_reg[PCR_LOCK_SEL_BIT] |=> (multiplexed_output_pin == $past(readback_sdo_in));
  endproperty
  a_mux_readback: assert property (p_mux_readback)
    else $error("mux pin not carrying readback data");

  property p_lock_disabled;
    @(posedge ref_clk) disable iff (!rstn)
      !lock_reg[PCR_LOCK_EN_BIT] ##1 !lock_reg[PCR_LOCK_EN_BIT] |=> !lock_detect_out ##0
        (!$past(lock_reg[PCR_LOCK_SEL_BIT]) || !multiplexed_output_pin);
  endproperty
  a_lock_disabled: assert property (p_lock_disabled)
    else $error("lock indication active while disabled");

  sequence s_settle3;
    settle_start && (multiplier_settle_count == 11'h003);
  endsequence

  property p_settle_len;
    @(posedge ref_clk) disable iff (!rstn)
      s_settle3 ##1 (!settle_start)[*3] |=> !settle_busy;
  endproperty
  a_settle_len: assert property (p_settle_len)
    else $error("settle wait longer than programmed count");

  property p_settle_hold;
    @(posedge ref_clk) disable iff (!rstn)
      s_settle3 |=> settle_busy[*3];
  endproperty
  a_settle_hold: assert property (p_settle_hold)
    else $error("settle wait shorter than programmed count");

  property p_mux_lock;
    @(posedge ref_clk) disable iff (!rstn)
      lock_reg[PCR_LOCK_SEL_BIT] |=> (multiplexed_output_pin == $past(lock_detect_out));
  endproperty
  a_mux_lock: assert property (p_mux_lock)
    else $error("mux pin not carrying lock indication");

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (!rstn)
      !reg_rd |=> (reg_rdata == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");

  sequence s_read_unmapped;
    reg_rd && (reg_addr != PCR_OFF_BUF) && (reg_addr != PCR_OFF_LOCK)
      && (reg_addr != PCR_OFF_INT) && (reg_addr != PCR_OFF_EXT);
  endsequence

  property p_unmapped_read;
    @(posedge ref_clk) disable iff (!rstn)
      s_read_unmapped |=> (reg_rdata == '0);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned nonzero data");

  property p_ext_write;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_wr && (reg_addr == PCR_OFF_EXT)) |=> (ext_reg == $past(reg_wdata));
  endproperty
  a_ext_write: assert property (p_ext_write)
    else $error("external pump register write did not land");

endmodule

/* logic/pcr_pkg.sv */
/*
  pcr_pkg: register offsets, reset values, field positions, gain codes
  and the pump-setting carrier for the pump and lock configuration bank.
  Assumes a single 100 MHz ref_clk domain and 16-bit registers.
*/
package pcr_pkg;

  localparam int unsigned PCR_AW = 8;
  localparam int unsigned PCR_DW = 16;
  localparam int unsigned PCR_WAIT_W = 11;

  // register offsets
  localparam logic [7:0] PCR_OFF_BUF = 8'h23;
  localparam logic [7:0] PCR_OFF_LOCK = 8'h27;
  localparam logic [7:0] PCR_OFF_INT = 8'h28;
  localparam logic [7:0] PCR_OFF_EXT = 8'h29;

  // reset values
  localparam logic [15:0] PCR_RST_BUF = 16'h0647;
  localparam logic [15:0] PCR_RST_LOCK = 16'h11f0;
  localparam logic [15:0] PCR_RST_INT = 16'h101c;
  localparam logic [15:0] PCR_RST_EXT = 16'h0810;

  // field positions
  localparam int unsigned PCR_EXT_UP_HI = 11;
  localparam int unsigned PCR_EXT_UP_LO = 7;
  localparam int unsigned PCR_EXT_GAIN_HI = 6;
  localparam int unsigned PCR_EXT_GAIN_LO = 5;
  localparam int unsigned PCR_INT_UP_HI = 12;
  localparam int unsigned PCR_INT_UP_LO = 8;
  localparam int unsigned PCR_INT_GAIN_HI = 7;
  localparam int unsigned PCR_INT_GAIN_LO = 6;
  localparam int unsigned PCR_INT_DN_HI = 4;
  localparam int unsigned PCR_INT_DN_LO = 0;
  localparam int unsigned PCR_LOCK_SEL_BIT = 3;
  localparam int unsigned PCR_LOCK_EN_BIT = 0;
  localparam int unsigned PCR_WAIT_HI = 13;
  localparam int unsigned PCR_WAIT_LO = 3;
  localparam int unsigned PCR_MUTE_BIT = 2;
  localparam int unsigned PCR_TX_BIT = 1;
  localparam int unsigned PCR_RX_BIT = 0;

  // one base code step per field, in nA
  localparam int unsigned PCR_CODE_STEP_NA = 156250;

  // gain multipliers in quarters
  localparam logic [3:0] PCR_GAIN_Q_1X = 4'h4;
  localparam logic [3:0] PCR_GAIN_Q_2X = 4'h8;
  localparam logic [3:0] PCR_GAIN_Q_1P5X = 4'h6;
  localparam logic [3:0] PCR_GAIN_Q_2P5X = 4'ha;

  typedef enum logic [1:0] {
    PCR_GAIN_1X = 2'b00,
    PCR_GAIN_2X = 2'b01,
    PCR_GAIN_1P5X = 2'b10,
    PCR_GAIN_2P5X = 2'b11
  } pcr_gain_type;

  // base_code in steps of 156.25 uA, filter_code in steps of 39.0625 uA
  typedef struct packed {
    logic tristate;
    logic [5:0] base_code;
    logic [3:0] gain_q;
    logic [9:0] filter_code;
  } pcr_pump_type;

endpackage

/* logic/pcr_pump_calc.sv */
/*
  pcr_pump_calc: turns up/down current codes and a gain code into the
  registered pump setting. Assumes codes come straight from the bank.
*/
`timescale 1ns/10ps
module pcr_pump_calc
  import pcr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [4:0] up_code,
  input wire logic [4:0] down_code,
  input wire logic [1:0] gain_code,
  output pcr_pump_type pump
);

  pcr_pump_type pump_reg;
  pcr_pump_type pump_next;
  pcr_gain_type gain_sel;

  always_comb begin
    gain_sel = pcr_gain_type'(gain_code);
    pump_next.base_code = {1'b0, up_code} + {1'b0, down_code};
    pump_next.tristate = (pump_next.base_code == 6'h00);
    case (gain_sel)
      PCR_GAIN_1X: pump_next.gain_q = PCR_GAIN_Q_1X;
      PCR_GAIN_2X: pump_next.gain_q = PCR_GAIN_Q_2X;
      PCR_GAIN_1P5X: pump_next.gain_q = PCR_GAIN_Q_1P5X;
      PCR_GAIN_2P5X: pump_next.gain_q = PCR_GAIN_Q_2P5X;
      default: pump_next.gain_q = PCR_GAIN_Q_1X;
    endcase
    pump_next.filter_code = {4'h0, pump_next.base_code} * {6'h00, pump_next.gain_q};
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pump_reg <= '0;
    end else begin
      pump_reg <= pump_next;
    end
  end

  assign pump = pump_reg;

endmodule

/* logic/pcr_settle_timer.sv */
/*
  pcr_settle_timer: holds busy for a programmed number of ref_clk cycles
  after each start pulse. Assumes start is a one-cycle pulse.
*/
`timescale 1ns/10ps
module pcr_settle_timer
  import pcr_pkg::*;
#(
  parameter int unsigned W = PCR_WAIT_W
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [W-1:0] count,
  output logic busy
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (start) begin
      cnt_next = count;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy = (cnt_reg != '0);

endmodule
